// >>> hdl/exec_pkg.sv
// Purpose: Shared constants and types of the instruction execution datapath
// Assumes: One clock at 40 MHz; a 14-bit instruction word per instruction
// Notes: Status byte reads {3'h0, expiry, sleep_entry, zero, nibble_carry, carry}
package exec_pkg;
	localparam int CYCLE_CLOCKS = 4;
	localparam int PHASE_W = $clog2(CYCLE_CLOCKS);
	localparam logic [PHASE_W-1:0] PH_FIRST = 2'h0;
	localparam logic [PHASE_W-1:0] PH_READ = 2'h1;
	localparam logic [PHASE_W-1:0] PH_EXEC = 2'h2;
	localparam logic [PHASE_W-1:0] PH_LAST = 2'h3;
	localparam int PC_W = 15;
	localparam int PTR_W = 16;
	localparam logic [2:0] REG_ACC = 3'h0;
	localparam logic [2:0] REG_STATUS = 3'h1;
	localparam logic [2:0] REG_UPPER = 3'h2;
	localparam logic [2:0] REG_PTR0_LO = 3'h3;
	localparam logic [2:0] REG_PTR0_HI = 3'h4;
	localparam logic [2:0] REG_PTR1_LO = 3'h5;
	localparam logic [2:0] REG_PTR1_HI = 3'h6;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [4:0] STATUS_RST = 5'h18;
	localparam logic [6:0] UPPER_RST = 7'h00;
	localparam logic [PC_W-1:0] PC_RST = 15'h0000;
	localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
	localparam logic [6:0] IND_ADDR0 = 7'h00;
	localparam logic [6:0] IND_ADDR1 = 7'h01;
	localparam logic [5:0] OPC6_ADD_FILE = 6'h07;
	localparam logic [5:0] OPC6_ADD_FILE_C = 6'h3d;
	localparam logic [5:0] OPC6_AND_FILE = 6'h05;
	localparam logic [5:0] OPC6_ASR = 6'h37;
	localparam logic [5:0] OPC6_ZERO = 6'h01;
	localparam logic [5:0] OPC6_COMP = 6'h09;
	localparam logic [5:0] OPC6_DEC = 6'h03;
	localparam logic [5:0] OPC6_DEC_SKIP = 6'h0b;
	localparam logic [5:0] OPC6_INC_SKIP = 6'h0f;
	localparam logic [5:0] OPC6_ADD_LIT = 6'h3e;
	localparam logic [5:0] OPC6_AND_LIT = 6'h39;
	localparam logic [3:0] OPC4_BIT_CLR = 4'h4;
	localparam logic [3:0] OPC4_BIT_SET = 4'h5;
	localparam logic [3:0] OPC4_SKIP_CLR = 4'h6;
	localparam logic [3:0] OPC4_SKIP_SET = 4'h7;
	localparam logic [4:0] OPC5_REL_JUMP = 5'h19;
	localparam logic [2:0] OPC3_INVOKE = 3'h4;
	localparam logic [2:0] OPC3_JUMP_ABS = 3'h5;
	localparam logic [6:0] OPC7_PTR_ADD = 7'h62;
	localparam logic [13:0] OPC_ACC_JUMP = 14'h000b;
	localparam logic [13:0] OPC_INVOKE_ACC = 14'h000a;
	localparam logic [13:0] OPC_WDOG_KICK = 14'h0064;

	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_STALL = 2'b10} exec_state_t;

	typedef enum logic [4:0] {
		K_IDLE = 5'b00000, K_ADD_FILE = 5'b00001, K_ADD_FILE_C = 5'b00010,
		K_AND_FILE = 5'b00011, K_ASR = 5'b00100, K_FILE_ZERO = 5'b00101,
		K_ACC_ZERO = 5'b00110, K_COMP = 5'b00111, K_DEC = 5'b01000,
		K_DEC_SKIP = 5'b01001, K_INC_SKIP = 5'b01010, K_BIT_CLR = 5'b01011,
		K_BIT_SET = 5'b01100, K_SKIP_CLR = 5'b01101, K_SKIP_SET = 5'b01110,
		K_ADD_LIT = 5'b01111, K_AND_LIT = 5'b10000, K_REL_JUMP = 5'b10001,
		K_ACC_JUMP = 5'b10010, K_INVOKE = 5'b10011, K_INVOKE_ACC = 5'b10100,
		K_JUMP_ABS = 5'b10101, K_WDOG_KICK = 5'b10110, K_PTR_ADD = 5'b10111
	} instr_kind_t;

	typedef enum logic [3:0] {
		A_PASS = 4'b0000, A_ADD = 4'b0001, A_ADDC = 4'b0010, A_AND = 4'b0011,
		A_ASR = 4'b0100, A_CLR = 4'b0101, A_COM = 4'b0110, A_DEC = 4'b0111,
		A_INC = 4'b1000, A_BCLR = 4'b1001, A_BSET = 4'b1010
	} alu_op_t;

	typedef struct packed {
		logic expiry;
		logic sleep_entry;
		logic zero;
		logic nibble_carry;
		logic carry;
	} status_t;

	typedef struct packed {
		logic [7:0] res;
		logic carry;
		logic nibble_carry;
		logic zero;
		logic upd_carry;
		logic upd_nibble;
		logic upd_zero;
	} alu_out_t;

	function automatic instr_kind_t decode_kind(input logic [13:0] w);
		instr_kind_t k;
		k = K_IDLE;
		if (w == OPC_ACC_JUMP) k = K_ACC_JUMP;
		else if (w == OPC_INVOKE_ACC) k = K_INVOKE_ACC;
		else if (w == OPC_WDOG_KICK) k = K_WDOG_KICK;
		else if (w[13:11] == OPC3_INVOKE) k = K_INVOKE;
		else if (w[13:11] == OPC3_JUMP_ABS) k = K_JUMP_ABS;
		else if (w[13:9] == OPC5_REL_JUMP) k = K_REL_JUMP;
		else if (w[13:7] == OPC7_PTR_ADD) k = K_PTR_ADD;
		else if (w[13:10] == OPC4_BIT_CLR) k = K_BIT_CLR;
		else if (w[13:10] == OPC4_BIT_SET) k = K_BIT_SET;
		else if (w[13:10] == OPC4_SKIP_CLR) k = K_SKIP_CLR;
		else if (w[13:10] == OPC4_SKIP_SET) k = K_SKIP_SET;
		else if (w[13:8] == OPC6_ZERO) k = w[7] ? K_FILE_ZERO : K_ACC_ZERO;
		else if (w[13:8] == OPC6_ADD_FILE) k = K_ADD_FILE;
		else if (w[13:8] == OPC6_ADD_FILE_C) k = K_ADD_FILE_C;
		else if (w[13:8] == OPC6_AND_FILE) k = K_AND_FILE;
		else if (w[13:8] == OPC6_ASR) k = K_ASR;
		else if (w[13:8] == OPC6_COMP) k = K_COMP;
		else if (w[13:8] == OPC6_DEC) k = K_DEC;
		else if (w[13:8] == OPC6_DEC_SKIP) k = K_DEC_SKIP;
		else if (w[13:8] == OPC6_INC_SKIP) k = K_INC_SKIP;
		else if (w[13:8] == OPC6_ADD_LIT) k = K_ADD_LIT;
		else if (w[13:8] == OPC6_AND_LIT) k = K_AND_LIT;
		return k;
	endfunction

	function automatic logic uses_file(input instr_kind_t k);
		return k inside {K_ADD_FILE, K_ADD_FILE_C, K_AND_FILE, K_ASR, K_FILE_ZERO, K_COMP,
			K_DEC, K_DEC_SKIP, K_INC_SKIP, K_BIT_CLR, K_BIT_SET, K_SKIP_CLR, K_SKIP_SET};
	endfunction

	// Indirect slot whose pointer has its top bit set
	function automatic logic slow_indirect(input logic [6:0] f, input logic [1:0][PTR_W-1:0] p);
		return (f == IND_ADDR0 && p[0][PTR_W-1]) || (f == IND_ADDR1 && p[1][PTR_W-1]);
	endfunction

	function automatic alu_op_t alu_op_for(input instr_kind_t k);
		unique case (k)
			K_ADD_FILE, K_ADD_LIT: return A_ADD;
			K_ADD_FILE_C: return A_ADDC;
			K_AND_FILE, K_AND_LIT: return A_AND;
			K_ASR: return A_ASR;
			K_FILE_ZERO, K_ACC_ZERO: return A_CLR;
			K_COMP: return A_COM;
			K_DEC, K_DEC_SKIP: return A_DEC;
			K_INC_SKIP: return A_INC;
			K_BIT_CLR: return A_BCLR;
			K_BIT_SET: return A_BSET;
			default: return A_PASS;
		endcase
	endfunction
endpackage

// >>> hdl/alu8.sv
// Purpose: Eight-bit arithmetic and logic unit of the execution datapath
// Assumes: Purely combinational; operands stable in the executing clock
// Notes: Update bits tell the caller which status flags the operation owns
`timescale 1ns/1ps
`default_nettype none
module alu8
	import exec_pkg::*;
(
	input wire exec_pkg::alu_op_t i_op,
	input wire logic [7:0] i_a,
	input wire logic [7:0] i_b,
	input wire logic i_carry,
	input wire logic [2:0] i_bit,
	output exec_pkg::alu_out_t o_out
);
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] mask;

	always_comb
	begin
		o_out = '0;
		mask = 8'h01 << i_bit;
		sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_carry && i_op == A_ADDC};
		nib = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_carry && i_op == A_ADDC};
		unique case (i_op)
			A_PASS: o_out.res = i_b;
			A_ADD, A_ADDC:
			begin
				o_out.res = sum[7:0];
				o_out.carry = sum[8];
				o_out.nibble_carry = nib[4];
				o_out.upd_carry = 1'b1;
				o_out.upd_nibble = 1'b1;
				o_out.upd_zero = 1'b1;
			end
			A_AND:
			begin
				o_out.res = i_a & i_b;
				o_out.upd_zero = 1'b1;
			end
			A_ASR:
			begin
				o_out.res = {i_b[7], i_b[7:1]};
				o_out.carry = i_b[0];
				o_out.upd_carry = 1'b1;
				o_out.upd_zero = 1'b1;
			end
			A_CLR: o_out.upd_zero = 1'b1;
			A_COM:
			begin
				o_out.res = ~i_b;
				o_out.upd_zero = 1'b1;
			end
			A_DEC:
			begin
				o_out.res = i_b - 8'h01;
				o_out.upd_zero = 1'b1;
			end
			A_INC: o_out.res = i_b + 8'h01;
			A_BCLR: o_out.res = i_b & ~mask;
			A_BSET: o_out.res = i_b | mask;
			default: o_out.res = i_b;
		endcase
		o_out.zero = (o_out.res == 8'h00);
	end
endmodule
`default_nettype wire

// >>> hdl/exec_core.sv
// Purpose: Executes a subset of an 8-bit core's instructions, four clocks per cycle
// Assumes: Fetch holds a word until taken; file read data arrive one clock after o_file_rd
// Notes: Execution commits on the clock closing phase 2; phase 3 carries the file write
`timescale 1ns/1ps
`default_nettype none
module exec_core
	import exec_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [13:0] i_instr,
	input wire logic i_instr_valid,
	output logic o_instr_ready,
	output logic [exec_pkg::PC_W-1:0] o_pc,
	output logic o_flush,
	output logic o_idle_slot,
	output logic [exec_pkg::PTR_W-1:0] o_file_addr,
	output logic o_file_rd,
	input wire logic [7:0] i_file_rdata,
	output logic o_file_wr,
	output logic [7:0] o_file_wdata,
	output logic o_push,
	output logic [exec_pkg::PC_W-1:0] o_push_addr,
	output logic o_wdog_clear,
	input wire logic [2:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata
);
	import exec_pkg::*;

	exec_state_t state_reg, state_next;
	instr_kind_t kind_reg, kind_next;
	status_t status_reg, status_next;
	alu_out_t alu_out;
	alu_op_t alu_op;
	logic [PHASE_W-1:0] phase_reg, phase_next;
	logic [1:0] extra_reg, extra_next;
	logic [13:0] ir_reg, ir_next;
	logic [PTR_W-1:0] addr_reg, addr_next;
	logic [7:0] acc_reg, acc_next, wdata_reg, wdata_next, rdata_reg, rdata_next, alu_b;
	logic [6:0] latch_reg, latch_next;
	logic [1:0][PTR_W-1:0] ptr_reg, ptr_next;
	logic [PC_W-1:0] pc_reg, pc_next, push_addr_reg, push_addr_next, pc_inc;
	logic file_wr_reg, file_wr_next, push_reg, push_next, kick_reg, kick_next;
	logic flush_reg, flush_next, skip, two_cycle, accept, exec_now;

	assign accept = state_reg == ST_IDLE && phase_reg == PH_FIRST && i_instr_valid;
	assign exec_now = state_reg == ST_EXEC && phase_reg == PH_EXEC;
	assign pc_inc = pc_reg + 15'h0001;
	assign alu_op = alu_op_for(kind_reg);
	assign alu_b = (kind_reg == K_ADD_LIT || kind_reg == K_AND_LIT) ? ir_reg[7:0] : i_file_rdata;

	alu8 u_alu (
		.i_op(alu_op),
		.i_a(acc_reg),
		.i_b(alu_b),
		.i_carry(status_reg.carry),
		.i_bit(ir_reg[9:7]),
		.o_out(alu_out)
	);

	always_comb
	begin
		state_next = state_reg;
		phase_next = phase_reg + 2'h1;
		extra_next = extra_reg;
		ir_next = ir_reg;
		kind_next = kind_reg;
		addr_next = addr_reg;
		acc_next = acc_reg;
		status_next = status_reg;
		latch_next = latch_reg;
		ptr_next = ptr_reg;
		pc_next = pc_reg;
		wdata_next = wdata_reg;
		push_addr_next = push_addr_reg;
		file_wr_next = 1'b0;
		push_next = 1'b0;
		kick_next = 1'b0;
		flush_next = 1'b0;
		skip = 1'b0;
		two_cycle = 1'b0;
		rdata_next = 8'h00;
		if (i_reg_rd)
			unique case (i_reg_addr)
				REG_ACC: rdata_next = acc_reg;
				REG_STATUS: rdata_next = {3'h0, status_reg};
				REG_UPPER: rdata_next = {1'b0, latch_reg};
				REG_PTR0_LO: rdata_next = ptr_reg[0][7:0];
				REG_PTR0_HI: rdata_next = ptr_reg[0][15:8];
				REG_PTR1_LO: rdata_next = ptr_reg[1][7:0];
				REG_PTR1_HI: rdata_next = ptr_reg[1][15:8];
				default: rdata_next = 8'h00;
			endcase
		if (i_reg_wr)
			unique case (i_reg_addr)
				REG_ACC: acc_next = i_reg_wdata;
				REG_STATUS: status_next = i_reg_wdata[4:0];
				REG_UPPER: latch_next = i_reg_wdata[6:0];
				REG_PTR0_LO: ptr_next[0][7:0] = i_reg_wdata;
				REG_PTR0_HI: ptr_next[0][15:8] = i_reg_wdata;
				REG_PTR1_LO: ptr_next[1][7:0] = i_reg_wdata;
				REG_PTR1_HI: ptr_next[1][15:8] = i_reg_wdata;
				default: acc_next = acc_reg;
			endcase
		unique case (state_reg)
			ST_IDLE:
				if (accept)
				begin
					state_next = ST_EXEC;
					ir_next = i_instr;
					kind_next = decode_kind(i_instr);
					addr_next = {9'h000, i_instr[6:0]};
					if (i_instr[6:0] == IND_ADDR0) addr_next = ptr_reg[0];
					if (i_instr[6:0] == IND_ADDR1) addr_next = ptr_reg[1];
					extra_next = {1'b0, uses_file(decode_kind(i_instr))
						&& slow_indirect(i_instr[6:0], ptr_reg)};
				end
			ST_EXEC:
			begin
				if (phase_reg == PH_EXEC)
				begin
					pc_next = pc_inc;
					wdata_next = alu_out.res;
					unique case (kind_reg)
						K_ADD_FILE, K_ADD_FILE_C, K_AND_FILE, K_ASR, K_COMP, K_DEC,
						K_DEC_SKIP, K_INC_SKIP:
						begin
							if (ir_reg[7]) file_wr_next = 1'b1;
							else acc_next = alu_out.res;
							if (kind_reg == K_DEC_SKIP || kind_reg == K_INC_SKIP)
								skip = alu_out.res == 8'h00;
						end
						K_FILE_ZERO: file_wr_next = 1'b1;
						K_ACC_ZERO, K_ADD_LIT, K_AND_LIT: acc_next = alu_out.res;
						K_BIT_CLR, K_BIT_SET: file_wr_next = 1'b1;
						K_SKIP_CLR: skip = !i_file_rdata[ir_reg[9:7]];
						K_SKIP_SET: skip = i_file_rdata[ir_reg[9:7]];
						K_REL_JUMP:
						begin
							pc_next = pc_inc + {{6{ir_reg[8]}}, ir_reg[8:0]};
							two_cycle = 1'b1;
						end
						K_ACC_JUMP:
						begin
							pc_next = pc_inc + {7'h00, acc_reg};
							two_cycle = 1'b1;
						end
						K_INVOKE, K_JUMP_ABS:
						begin
							push_next = kind_reg == K_INVOKE;
							push_addr_next = pc_inc;
							pc_next = {latch_reg[6:3], ir_reg[10:0]};
							two_cycle = 1'b1;
						end
						K_INVOKE_ACC:
						begin
							push_next = 1'b1;
							push_addr_next = pc_inc;
							pc_next = {latch_reg, acc_reg};
							two_cycle = 1'b1;
						end
						K_WDOG_KICK:
						begin
							kick_next = 1'b1;
							status_next.expiry = 1'b1;
							status_next.sleep_entry = 1'b1;
						end
						K_PTR_ADD:
							ptr_next[ir_reg[6]] = ptr_reg[ir_reg[6]] + {{10{ir_reg[5]}}, ir_reg[5:0]};
						default: pc_next = pc_inc;
					endcase
					if (kind_reg != K_DEC_SKIP && kind_reg != K_INC_SKIP)
					begin
						if (alu_out.upd_carry) status_next.carry = alu_out.carry;
						if (alu_out.upd_nibble) status_next.nibble_carry = alu_out.nibble_carry;
						if (alu_out.upd_zero) status_next.zero = alu_out.zero;
					end
					if (skip)
					begin
						pc_next = pc_reg + 15'h0002;
						two_cycle = 1'b1;
					end
					extra_next = extra_reg + {1'b0, two_cycle};
					flush_next = two_cycle;
				end
				else if (phase_reg == PH_LAST)
					state_next = (extra_reg != 2'h0) ? ST_STALL : ST_IDLE;
			end
			ST_STALL:
				if (phase_reg == PH_LAST)
				begin
					extra_next = extra_reg - 2'h1;
					if (extra_reg == 2'h1) state_next = ST_IDLE;
				end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			state_reg <= ST_IDLE;
			phase_reg <= PH_FIRST;
			extra_reg <= 2'h0;
			ir_reg <= 14'h0000;
			kind_reg <= K_IDLE;
			addr_reg <= PTR_RST;
			acc_reg <= ACC_RST;
			status_reg <= STATUS_RST;
			latch_reg <= UPPER_RST;
			ptr_reg <= {PTR_RST, PTR_RST};
			pc_reg <= PC_RST;
			wdata_reg <= 8'h00;
			push_addr_reg <= PC_RST;
			file_wr_reg <= 1'b0;
			push_reg <= 1'b0;
			kick_reg <= 1'b0;
			flush_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			phase_reg <= phase_next;
			extra_reg <= extra_next;
			ir_reg <= ir_next;
			kind_reg <= kind_next;
			addr_reg <= addr_next;
			acc_reg <= acc_next;
			status_reg <= status_next;
			latch_reg <= latch_next;
			ptr_reg <= ptr_next;
			pc_reg <= pc_next;
			wdata_reg <= wdata_next;
			push_addr_reg <= push_addr_next;
			file_wr_reg <= file_wr_next;
			push_reg <= push_next;
			kick_reg <= kick_next;
			flush_reg <= flush_next;
			rdata_reg <= rdata_next;
		end
	end

	assign o_instr_ready = state_reg == ST_IDLE && phase_reg == PH_FIRST;
	assign o_file_rd = state_reg == ST_EXEC && phase_reg == PH_READ && uses_file(kind_reg);
	assign o_idle_slot = state_reg == ST_STALL;
	assign o_pc = pc_reg;
	assign o_flush = flush_reg;
	assign o_file_addr = addr_reg;
	assign o_file_wr = file_wr_reg;
	assign o_file_wdata = wdata_reg;
	assign o_push = push_reg;
	assign o_push_addr = push_addr_reg;
	assign o_wdog_clear = kick_reg;
	assign o_reg_rdata = rdata_reg;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	property p_cycle_len;
		accept |=> (state_reg == ST_EXEC) [*3] ##1 (state_reg != ST_EXEC);
	endproperty
	a_cycle_len: assert property (p_cycle_len) else $error("execution not four clocks");

	property p_idle_second;
		exec_now && kind_reg == K_JUMP_ABS && extra_reg == 2'h0 |=>
			state_reg == ST_EXEC ##1 (o_idle_slot) [*4] ##1 o_instr_ready;
	endproperty
	a_idle_second: assert property (p_idle_second) else $error("jump lacks idle cycle");

	property p_slow_ind;
		accept && uses_file(decode_kind(i_instr)) && slow_indirect(i_instr[6:0], ptr_reg)
			|=> extra_reg == 2'h1;
	endproperty
	a_slow_ind: assert property (p_slow_ind) else $error("no extra indirect cycle");

	property p_ptr_add;
		exec_now && kind_reg == K_PTR_ADD && !i_reg_wr |=> $stable(status_reg)
			&& ptr_reg[$past(ir_reg[6])] - $past(ptr_reg[ir_reg[6]])
			== {{10{$past(ir_reg[5])}}, $past(ir_reg[5:0])};
	endproperty
	a_ptr_add: assert property (p_ptr_add) else $error("pointer add wrong");

	property p_dest_acc;
		exec_now && kind_reg == K_ADD_FILE && !ir_reg[7] && !i_reg_wr |=>
			!o_file_wr && acc_reg == $past(acc_reg) + $past(i_file_rdata);
	endproperty
	a_dest_acc: assert property (p_dest_acc) else $error("destination routing wrong");

	property p_and_lit;
		exec_now && kind_reg == K_AND_LIT && !i_reg_wr |=> acc_reg == ($past(acc_reg)
			& $past(ir_reg[7:0])) && status_reg.carry == $past(status_reg.carry)
			&& status_reg.zero == (acc_reg == 8'h00);
	endproperty
	a_and_lit: assert property (p_and_lit) else $error("literal AND wrong");

	property p_skip_clr;
		exec_now && kind_reg == K_SKIP_CLR && !i_file_rdata[ir_reg[9:7]] |=>
			pc_reg == $past(pc_reg) + 15'h0002 && o_flush;
	endproperty
	a_skip_clr: assert property (p_skip_clr) else $error("clear-skip missed");

	property p_rel_jump;
		exec_now && kind_reg == K_REL_JUMP |=>
			pc_reg - $past(pc_reg) - 15'h0001 == {{6{$past(ir_reg[8])}}, $past(ir_reg[8:0])};
	endproperty
	a_rel_jump: assert property (p_rel_jump) else $error("relative target wrong");

	property p_invoke;
		exec_now && kind_reg == K_INVOKE |=> o_push && o_push_addr == $past(pc_reg) + 15'h0001
			&& pc_reg[10:0] == $past(ir_reg[10:0]) && pc_reg[14:11] == $past(latch_reg[6:3]);
	endproperty
	a_invoke: assert property (p_invoke) else $error("invoke wrong");

	property p_kick;
		exec_now && kind_reg == K_WDOG_KICK |=> o_wdog_clear && status_reg.expiry
			&& status_reg.sleep_entry ##1 !o_wdog_clear;
	endproperty
	a_kick: assert property (p_kick) else $error("watchdog kick wrong");

	property p_zeroing;
		exec_now && kind_reg == K_FILE_ZERO && !i_reg_wr |=> o_file_wr
			&& o_file_wdata == 8'h00 && status_reg.zero;
	endproperty
	a_zeroing: assert property (p_zeroing) else $error("file zeroing wrong");

	c_skip_taken: cover property (exec_now && kind_reg == K_SKIP_SET && skip);
	c_invoke_acc: cover property (exec_now && kind_reg == K_INVOKE_ACC);
	c_slow_stall: cover property (state_reg == ST_STALL && extra_reg == 2'h2);
	c_carry_add: cover property (exec_now && kind_reg == K_ADD_FILE_C && status_reg.carry);
endmodule
`default_nettype wire

// >>> bench/exec_core_tb.sv
// Purpose: Self-checking bench of the instruction execution datapath
// Assumes: The bench plays fetch, file memory and software port
// Notes: Expected values come from opcode fields and flag arithmetic
`timescale 1ns/1ps
`default_nettype none
module exec_core_tb;
	import exec_pkg::*;
	logic clk = 0, rst = 1, iv = 0, rw = 0, rr = 0;
	logic [13:0] ins = 0;
	logic [7:0] fd = 0, wd = 0, rq, fwd, v;
	logic [2:0] ra = 0;
	logic [14:0] pc, pa, pe, x = 0, y;
	logic [15:0] fa, a;
	logic rdy, fl, idl, frd, fwr, pu, wk, w, f, p, k, i, r;
	logic [3:0] n;
	int fail_count = 0, tests_run = 0, cyc = 0;
	always #12.5 clk = ~clk;
	exec_core DUT (.i_ref_clk(clk), .i_rst(rst), .i_instr(ins), .i_instr_valid(iv),
		.o_instr_ready(rdy), .o_pc(pc), .o_flush(fl), .o_idle_slot(idl),
		.o_file_addr(fa), .o_file_rd(frd), .i_file_rdata(fd), .o_file_wr(fwr),
		.o_file_wdata(fwd), .o_push(pu), .o_push_addr(pa), .o_wdog_clear(wk),
		.i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(rw), .i_reg_rd(rr), .o_reg_rdata(rq));
	task automatic summarize();
		if (fail_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fail_count++;
			summarize();
		end
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e)
		begin
			fail_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [2:0] ad, input logic [7:0] d);
		@(posedge clk);
		ra <= ad;
		wd <= d;
		rw <= 1;
		@(posedge clk);
		rw <= 0;
	endtask
	task automatic rd(input logic [2:0] ad, input logic [7:0] e);
		@(posedge clk);
		ra <= ad;
		rr <= 1;
		@(posedge clk);
		rr <= 0;
		@(negedge clk);
		chk(rq, e);
	endtask
	// Offers one word, samples the commit clock, then measures the cycle length
	task automatic run(input logic [13:0] c, input logic [7:0] d, input logic [14:0] np,
		input logic [3:0] ln);
		@(posedge clk);
		ins <= c;
		fd <= d;
		iv <= 1;
		@(negedge clk);
		while (rdy !== 1'b1)
			@(negedge clk);
		@(posedge clk);
		iv <= 0;
		@(negedge clk);
		r = frd;
		repeat (2) @(negedge clk);
		{w, v, f, p, k, pe, a} = {fwr, fwd, fl, pu, wk, pa, fa};
		chk(pc, np);
		x = np;
		n = 4'h4;
		@(negedge clk);
		i = idl;
		while (rdy !== 1'b1)
		begin
			n = n + 4'h1;
			@(negedge clk);
		end
		chk(n, ln);
	endtask
	task automatic sk(input logic [13:0] c, input logic [7:0] d, input logic s);
		run(c, d, x + (s ? 15'h2 : 15'h1), s ? 4'h8 : 4'h4);
		chk({f, i}, {s, s});
	endtask
	task automatic jp(input logic [13:0] c, input logic [14:0] np);
		y = x;
		run(c, 8'h00, np, 4'h8);
		chk({f, i}, 2'b11);
	endtask
	task automatic t_rst();
		rd(3'h1, 8'h18);
		wr(3'h7, 8'hff);
		rd(3'h7, 8'h00);
		chk(pc, 16'h0000);
	endtask
	task automatic t_alu();
		wr(3'h0, 8'h8f);
		run({OPC6_ADD_LIT, 8'h71}, 8'h00, x + 15'h1, 4'h4);
		chk(r, 1'b0);
		rd(3'h0, 8'h00);
		rd(3'h1, 8'h1f);
		wr(3'h0, 8'hf0);
		wr(3'h1, 8'h13);
		run({OPC6_AND_LIT, 8'h0f}, 8'h00, x + 15'h1, 4'h4);
		rd(3'h1, 8'h17);
		rd(3'h0, 8'h00);
		wr(3'h0, 8'h01);
		wr(3'h1, 8'h19);
		run({OPC6_ADD_FILE, 1'b1, 7'h20}, 8'h0f, x + 15'h1, 4'h4);
		chk({w, v}, 9'h110);
		chk(a, 16'h0020);
		chk(r, 1'b1);
		rd(3'h1, 8'h1a);
		wr(3'h0, 8'h80);
		wr(3'h1, 8'h19);
		run({OPC6_ADD_FILE_C, 1'b0, 7'h20}, 8'h7f, x + 15'h1, 4'h4);
		chk(w, 1'b0);
		rd(3'h0, 8'h00);
		rd(3'h1, 8'h1f);
		wr(3'h0, 8'h3c);
		wr(3'h1, 8'h1b);
		run({OPC6_AND_FILE, 1'b0, 7'h20}, 8'hc3, x + 15'h1, 4'h4);
		rd(3'h1, 8'h1f);
		wr(3'h1, 8'h18);
		run({OPC6_ASR, 1'b1, 7'h21}, 8'h81, x + 15'h1, 4'h4);
		chk({w, v}, 9'h1c0);
		rd(3'h1, 8'h19);
		wr(3'h1, 8'h1f);
		run({OPC4_BIT_SET, 3'h7, 7'h21}, 8'h00, x + 15'h1, 4'h4);
		chk({w, v}, 9'h180);
		run({OPC4_BIT_CLR, 3'h0, 7'h21}, 8'hff, x + 15'h1, 4'h4);
		chk({w, v}, 9'h1fe);
		rd(3'h1, 8'h1f);
		run({OPC6_ADD_FILE, 1'b0, 7'h25}, 8'h9e, x + 15'h1, 4'h4);
		chk(w, 1'b0);
		rd(3'h0, 8'h9e);
		rd(3'h1, 8'h18);
	endtask
	task automatic t_skip();
		sk({OPC4_SKIP_CLR, 3'h3, 7'h22}, 8'hf7, 1'b1);
		sk({OPC4_SKIP_CLR, 3'h3, 7'h22}, 8'h08, 1'b0);
		sk({OPC4_SKIP_SET, 3'h3, 7'h22}, 8'h08, 1'b1);
		sk({OPC4_SKIP_SET, 3'h3, 7'h22}, 8'hf7, 1'b0);
		wr(3'h1, 8'h1b);
		sk({OPC6_DEC_SKIP, 1'b1, 7'h23}, 8'h01, 1'b1);
		chk({w, v}, 9'h100);
		sk({OPC6_DEC_SKIP, 1'b1, 7'h23}, 8'h02, 1'b0);
		chk({w, v}, 9'h101);
		sk({OPC6_INC_SKIP, 1'b0, 7'h23}, 8'hff, 1'b1);
		rd(3'h0, 8'h00);
		rd(3'h1, 8'h1b);
	endtask
	task automatic t_zero();
		wr(3'h0, 8'h55);
		wr(3'h1, 8'h18);
		run({OPC6_ZERO, 1'b0, 7'h00}, 8'h00, x + 15'h1, 4'h4);
		rd(3'h0, 8'h00);
		rd(3'h1, 8'h1c);
		wr(3'h1, 8'h18);
		run({OPC6_ZERO, 1'b1, 7'h24}, 8'haa, x + 15'h1, 4'h4);
		chk({w, v}, 9'h100);
		rd(3'h1, 8'h1c);
		wr(3'h1, 8'h1b);
		run({OPC6_DEC, 1'b0, 7'h24}, 8'h01, x + 15'h1, 4'h4);
		rd(3'h0, 8'h00);
		rd(3'h1, 8'h1f);
		run({OPC6_COMP, 1'b1, 7'h24}, 8'h0f, x + 15'h1, 4'h4);
		chk({w, v}, 9'h1f0);
		rd(3'h1, 8'h1b);
	endtask
	task automatic t_jump();
		wr(3'h2, 8'h28);
		jp({OPC3_INVOKE, 11'h123}, 15'h2923);
		chk({p, pe}, {1'b1, y + 15'h1});
		wr(3'h0, 8'h34);
		wr(3'h2, 8'h55);
		jp(OPC_INVOKE_ACC, {7'h55, 8'h34});
		chk({p, pe}, {1'b1, y + 15'h1});
		wr(3'h2, 8'h50);
		jp({OPC3_JUMP_ABS, 11'h7ff}, 15'h57ff);
		chk(p, 1'b0);
		rd(3'h2, 8'h50);
		jp({OPC5_REL_JUMP, 9'h100}, x + 15'h1 - 15'h100);
		jp({OPC5_REL_JUMP, 9'h0ff}, x + 15'h100);
		wr(3'h0, 8'hff);
		jp(OPC_ACC_JUMP, x + 15'h100);
		rd(3'h1, 8'h1b);
	endtask
	task automatic t_ptr();
		wr(3'h3, 8'hff);
		wr(3'h4, 8'hff);
		run({OPC7_PTR_ADD, 1'b0, 6'h01}, 8'h00, x + 15'h1, 4'h4);
		rd(3'h3, 8'h00);
		rd(3'h4, 8'h00);
		run({OPC7_PTR_ADD, 1'b1, 6'h20}, 8'h00, x + 15'h1, 4'h4);
		rd(3'h5, 8'he0);
		rd(3'h6, 8'hff);
		rd(3'h1, 8'h1b);
		wr(3'h4, 8'h80);
		run({OPC6_ADD_FILE, 1'b1, 7'h00}, 8'h00, x + 15'h1, 4'h8);
		chk(a, 16'h8000);
		chk({i, f}, 2'b10);
		wr(3'h6, 8'h7f);
		run({OPC6_ADD_FILE, 1'b1, 7'h01}, 8'h00, x + 15'h1, 4'h4);
		chk(a, 16'h7fe0);
		wr(3'h1, 8'h00);
		run(OPC_WDOG_KICK, 8'h00, x + 15'h1, 4'h4);
		chk(k, 1'b1);
		rd(3'h1, 8'h18);
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 0;
		t_rst();
		t_alu();
		t_skip();
		t_zero();
		t_jump();
		t_ptr();
		summarize();
	end
endmodule
`default_nettype wire
